/* rtl/fifo_pair_defs.vh */
// Purpose: constants for the two-way clocked buffer pair
// Assumes: included by the design files by bare name
// Notes: depth, widths, flag thresholds
`ifndef FIFO_PAIR_DEFS_VH
`define FIFO_PAIR_DEFS_VH
`define WORD_WIDTH 18
`define DEPTH 512
`define ADDR_WIDTH 9
`define PTR_WIDTH 10
`define HALF_LEVEL 10'h100
`define ALMOST_OFFSET_DEFAULT 10'h00C
`define RESET_EDGES 3'h4
`define IR_RELEASE_EDGES 2'h2
`endif

/* rtl/one_way_buffer.v */
// Purpose: one 512 x 18 buffer between a write port and a read port
// Assumes: both port clocks sampled by clk; strobes are port-clock edge pulses
// Notes: flags leave through two flops on the port that shows them
`timescale 1ns/100ps
`default_nettype none
`include "fifo_pair_defs.vh"
module one_way_buffer (
  input wire clk,
  input wire reset,
  input wire wr_edge,
  input wire rd_edge,
  input wire clear_n,
  input wire wr_req,
  input wire rd_req,
  input wire [17:0] wr_data,
  output reg [17:0] rd_data,
  output reg input_ready,
  output reg output_ready,
  output reg half_full,
  output reg almost_flag
);
  reg [17:0] mem [0:511];
  reg [9:0] wr_ptr;
  reg [9:0] rd_ptr;
  reg [9:0] wr_gray;
  reg [9:0] rd_gray;
  reg [9:0] rd_gray_s1;
  reg [9:0] rd_gray_s2;
  reg [9:0] wr_gray_s1;
  reg [9:0] wr_gray_s2;
  reg full_s1;
  reg [2:0] clr_wr_cnt;
  reg [2:0] clr_rd_cnt;
  reg [1:0] ir_hold;
  wire [9:0] rd_seen;
  wire [9:0] wr_seen;
  wire [9:0] level;
  wire [9:0] level_next;
  wire wr_do;
  wire rd_do;
  wire in_clear_w;
  wire in_clear_r;

  function [9:0] to_gray;
    input [9:0] b;
    to_gray = b ^ {1'b0, b[9:1]};
  endfunction

  function [9:0] from_gray;
    input [9:0] g;
    integer i;
    begin
      from_gray[9] = g[9];
      for (i = 8; i >= 0; i = i - 1) begin
        from_gray[i] = from_gray[i + 1] ^ g[i];
      end
    end
  endfunction

  assign in_clear_w = (clr_wr_cnt != 3'h0);
  assign in_clear_r = (clr_rd_cnt != 3'h0);
  assign rd_seen = from_gray(rd_gray_s2);
  assign wr_seen = from_gray(wr_gray_s2);
  assign level = wr_ptr - rd_seen;
  // fill after this edge, so the flags match the words now held
  assign level_next = level + {9'h000, wr_do};
  // writes refused while input-ready low; reads refused while output-ready low
  assign wr_do = wr_edge & wr_req & input_ready & ~in_clear_w;
  assign rd_do = rd_edge & rd_req & output_ready & ~in_clear_r;

  // write side; one write-clock edge with clear_n low clears; the edge count stops at four
  always @(posedge clk) begin
    if (reset) begin
      wr_ptr <= 10'h000;
      wr_gray <= 10'h000;
      clr_wr_cnt <= 3'h0;
      ir_hold <= 2'h0;
      input_ready <= 1'b0;
      full_s1 <= 1'b0;
      half_full <= 1'b0;
      almost_flag <= 1'b1;
      rd_gray_s1 <= 10'h000;
      rd_gray_s2 <= 10'h000;
    end else if (wr_edge) begin
      // gray read pointer carried into write side
      rd_gray_s1 <= rd_gray;
      rd_gray_s2 <= rd_gray_s1;
      if (!clear_n) begin
        wr_ptr <= 10'h000;
        wr_gray <= 10'h000;
        input_ready <= 1'b0;
        full_s1 <= 1'b0;
        half_full <= 1'b0;
        almost_flag <= 1'b1;
        ir_hold <= `IR_RELEASE_EDGES;
        if (clr_wr_cnt != `RESET_EDGES) begin
          clr_wr_cnt <= clr_wr_cnt + 3'h1;
        end
      end else begin
        clr_wr_cnt <= 3'h0;
        if (wr_do) begin
          mem[wr_ptr[8:0]] <= wr_data; // fifo order kept by pointer order
          wr_ptr <= wr_ptr + 10'h001;
          wr_gray <= to_gray(wr_ptr + 10'h001);
        end
        if (ir_hold != 2'h0) begin
          ir_hold <= ir_hold - 2'h1;
        end
        // not-full rises through two stages; the filling write drops it at once
        full_s1 <= (level_next != 10'h200);
        input_ready <= full_s1 && (level_next != 10'h200) && (ir_hold <= 2'h1);
        half_full <= (level_next >= `HALF_LEVEL);
        almost_flag <= (level_next <= `ALMOST_OFFSET_DEFAULT) ||
          (level_next >= (10'h200 - `ALMOST_OFFSET_DEFAULT));
      end
    end
  end

  // read side; output word loaded as output-ready rises or on a read with a word waiting, held while low
  always @(posedge clk) begin
    if (reset) begin
      rd_ptr <= 10'h000;
      rd_gray <= 10'h000;
      clr_rd_cnt <= 3'h0;
      output_ready <= 1'b0;
      rd_data <= 18'h00000;
      wr_gray_s1 <= 10'h000;
      wr_gray_s2 <= 10'h000;
    end else if (rd_edge) begin
      // gray write pointer carried into read side
      wr_gray_s1 <= wr_gray;
      wr_gray_s2 <= wr_gray_s1;
      if (!clear_n) begin
        rd_ptr <= 10'h000;
        rd_gray <= 10'h000;
        output_ready <= 1'b0;
        if (clr_rd_cnt != `RESET_EDGES) begin
          clr_rd_cnt <= clr_rd_cnt + 3'h1;
        end
      end else begin
        clr_rd_cnt <= 3'h0;
        // a word counts as stored until the host takes it from the output register
        if (rd_do) begin
          output_ready <= 1'b0;
          rd_gray <= to_gray(rd_ptr);
        end
        // third read edge after the write: two sync stages then flag
        if ((!output_ready || rd_do) && (wr_seen != rd_ptr)) begin
          rd_data <= mem[rd_ptr[8:0]];
          rd_ptr <= rd_ptr + 10'h001;
          output_ready <= 1'b1;
        end
      end
    end
  end
endmodule // one_way_buffer
`default_nettype wire

/* rtl/clocked_fifo_pair.v */
// Purpose: two-way clocked buffer pair, ports A and B
// Assumes: port clocks and pins are sampled by clk (250 MHz), far slower than clk
// Notes: data pins are split into in, out and enable
`timescale 1ns/100ps
`default_nettype none
`include "fifo_pair_defs.vh"
module clocked_fifo_pair (
  input wire clk,
  input wire reset,
  input wire port_a_clock,
  input wire port_b_clock,
  input wire port_a_select_n,
  input wire port_b_select_n,
  input wire port_a_dir_select,
  input wire port_b_dir_select,
  input wire port_a_write_enable,
  input wire port_b_write_enable,
  input wire port_a_read_enable,
  input wire port_b_read_enable,
  input wire a_to_b_reset_n,
  input wire b_to_a_reset_n,
  input wire [17:0] port_a_data_in,
  input wire [17:0] port_b_data_in,
  output reg [17:0] port_a_data_out,
  output reg [17:0] port_b_data_out,
  output reg port_a_data_oe,
  output reg port_b_data_oe,
  output reg port_a_input_ready,
  output reg port_b_input_ready,
  output reg port_a_output_ready,
  output reg port_b_output_ready,
  output reg a_to_b_half_full,
  output reg b_to_a_half_full,
  output reg a_to_b_almost_flag,
  output reg b_to_a_almost_flag
);
  // first and second synchroniser stages for every pin input except the two resets
  reg [45:0] pins_s1;
  reg [45:0] pins_s2;
  reg port_a_clock_prev;
  reg port_b_clock_prev;
  wire [45:0] pins_raw;
  wire port_a_clock_rise;
  wire port_b_clock_rise;
  wire sel_a_n;
  wire sel_b_n;
  wire dir_a;
  wire dir_b;
  wire wen_a;
  wire wen_b;
  wire ren_a;
  wire ren_b;
  wire rst_ab_n;
  wire rst_ba_n;
  wire [17:0] din_a;
  wire [17:0] din_b;
  wire ab_wr_req;
  wire ab_rd_req;
  wire ba_wr_req;
  wire ba_rd_req;
  wire [17:0] ab_out;
  wire [17:0] ba_out;
  wire ab_ir;
  wire ab_or;
  wire ab_hf;
  wire ab_af;
  wire ba_ir;
  wire ba_or;
  wire ba_hf;
  wire ba_af;

  assign pins_raw = {port_a_clock, port_b_clock, port_a_select_n, port_b_select_n,
    port_a_dir_select, port_b_dir_select, port_a_write_enable, port_b_write_enable,
    port_a_read_enable, port_b_read_enable, port_a_data_in, port_b_data_in};

  // two flops before any logic looks at a pin; each port clock is just a sampled level
  always @(posedge clk) begin
    if (reset) begin
      pins_s1 <= 46'h0F0000000000; // selects and directions idle high
      pins_s2 <= 46'h0F0000000000;
      port_a_clock_prev <= 1'b0;
      port_b_clock_prev <= 1'b0;
    end else begin
      pins_s1 <= pins_raw;
      pins_s2 <= pins_s1;
      port_a_clock_prev <= pins_s2[45];
      port_b_clock_prev <= pins_s2[44];
    end
  end

  // resets are sampled separately, held asserted while reset is high
  reg [1:0] rst_s1;
  reg [1:0] rst_s2;
  always @(posedge clk) begin
    if (reset) begin
      rst_s1 <= 2'h0;
      rst_s2 <= 2'h0;
    end else begin
      rst_s1 <= {a_to_b_reset_n, b_to_a_reset_n};
      rst_s2 <= rst_s1;
    end
  end

  assign port_a_clock_rise = pins_s2[45] & ~port_a_clock_prev;
  assign port_b_clock_rise = pins_s2[44] & ~port_b_clock_prev;
  assign sel_a_n = pins_s2[43];
  assign sel_b_n = pins_s2[42];
  assign dir_a = pins_s2[41];
  assign dir_b = pins_s2[40];
  assign wen_a = pins_s2[39];
  assign wen_b = pins_s2[38];
  assign ren_a = pins_s2[37];
  assign ren_b = pins_s2[36];
  assign din_a = pins_s2[35:18];
  assign din_b = pins_s2[17:0];
  assign rst_ab_n = rst_s2[1];
  assign rst_ba_n = rst_s2[0];

  // operations only with select low; enables low start nothing
  assign ab_wr_req = ~sel_a_n & dir_a & wen_a;
  assign ba_rd_req = ~sel_a_n & ~dir_a & ren_a;
  assign ba_wr_req = ~sel_b_n & dir_b & wen_b;
  assign ab_rd_req = ~sel_b_n & ~dir_b & ren_b;

  // a to b: written on port A edges, read on port B edges
  one_way_buffer a_to_b_buffer (
    .clk(clk),
    .reset(reset),
    .wr_edge(port_a_clock_rise),
    .rd_edge(port_b_clock_rise),
    .clear_n(rst_ab_n),
    .wr_req(ab_wr_req),
    .rd_req(ab_rd_req),
    .wr_data(din_a),
    .rd_data(ab_out),
    .input_ready(ab_ir),
    .output_ready(ab_or),
    .half_full(ab_hf),
    .almost_flag(ab_af)
  );

  // b to a: written on port B edges, read on port A edges
  one_way_buffer b_to_a_buffer (
    .clk(clk),
    .reset(reset),
    .wr_edge(port_b_clock_rise),
    .rd_edge(port_a_clock_rise),
    .clear_n(rst_ba_n),
    .wr_req(ba_wr_req),
    .rd_req(ba_rd_req),
    .wr_data(din_b),
    .rd_data(ba_out),
    .input_ready(ba_ir),
    .output_ready(ba_or),
    .half_full(ba_hf),
    .almost_flag(ba_af)
  );

  // output flops; drive follows select and direction, not the clock
  always @(posedge clk) begin
    if (reset) begin
      port_a_data_out <= 18'h00000;
      port_b_data_out <= 18'h00000;
      port_a_data_oe <= 1'b0;
      port_b_data_oe <= 1'b0;
      port_a_input_ready <= 1'b0;
      port_b_input_ready <= 1'b0;
      port_a_output_ready <= 1'b0;
      port_b_output_ready <= 1'b0;
      a_to_b_half_full <= 1'b0;
      b_to_a_half_full <= 1'b0;
      a_to_b_almost_flag <= 1'b1;
      b_to_a_almost_flag <= 1'b1;
    end else begin
      port_a_data_out <= ba_out;
      port_b_data_out <= ab_out;
      port_a_data_oe <= ~sel_a_n & ~dir_a;
      port_b_data_oe <= ~sel_b_n & ~dir_b;
      port_a_input_ready <= ab_ir;
      port_b_input_ready <= ba_ir;
      port_a_output_ready <= ba_or;
      port_b_output_ready <= ab_or;
      a_to_b_half_full <= ab_hf;
      b_to_a_half_full <= ba_hf;
      a_to_b_almost_flag <= ab_af;
      b_to_a_almost_flag <= ba_af;
    end
  end
endmodule // clocked_fifo_pair
`default_nettype wire

/* tb/fifo_pair_chk.sv */
// Purpose: pin-level assertions for the buffer pair
// Assumes: bound to the top module; one clk domain
// Notes: ready-flag and word moves must land while the port clock is high
`timescale 1ns/100ps
`default_nettype none
module fifo_pair_chk (
  input wire logic clk,
  input wire logic reset,
  input wire logic port_a_clock,
  input wire logic port_b_clock,
  input wire logic port_a_select_n,
  input wire logic port_a_dir_select,
  input wire logic a_to_b_reset_n,
  input wire logic port_a_data_oe,
  input wire logic port_a_input_ready,
  input wire logic port_b_output_ready,
  input wire logic [17:0] port_b_data_out,
  input wire logic a_to_b_half_full,
  input wire logic a_to_b_almost_flag
);
  logic [7:0] clr;
  // clear length in clk cycles; saturates so a long clear stays quiet
  always_ff @(posedge clk) begin
    if (reset || a_to_b_reset_n) clr <= 8'h00;
    else if (clr != 8'hFF) clr <= clr + 8'h01;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  a_oe_a_off: assert property ((port_a_select_n || port_a_dir_select) [*8] |-> !port_a_data_oe)
    else $error("a pins driven");
  a_oe_a_on: assert property ((!port_a_select_n && !port_a_dir_select) [*8] |-> port_a_data_oe)
    else $error("a pins idle");
  a_hold_b_word: assert property (!port_b_output_ready |=> port_b_output_ready || $stable(port_b_data_out))
    else $error("b word lost");
  a_clear_ab: assert property (clr == 8'hC8 |->
    !port_a_input_ready && !port_b_output_ready && !a_to_b_half_full && a_to_b_almost_flag)
    else $error("clear flags wrong");
  a_full_ab: assert property (!port_a_input_ready && port_b_output_ready |->
    a_to_b_half_full && a_to_b_almost_flag)
    else $error("full flags wrong");
  a_ira_edge: assert property ($changed(port_a_input_ready) && a_to_b_reset_n |-> port_a_clock)
    else $error("a ready off edge");
  a_orb_edge: assert property ($changed(port_b_output_ready) && a_to_b_reset_n |-> port_b_clock)
    else $error("b ready off edge");
  a_outb_edge: assert property ($changed(port_b_data_out) && a_to_b_reset_n |-> port_b_clock)
    else $error("b word off edge");
endmodule // fifo_pair_chk
bind clocked_fifo_pair fifo_pair_chk fifo_pair_chk_i (.clk, .reset, .port_a_clock, .port_b_clock,
  .port_a_select_n, .port_a_dir_select, .a_to_b_reset_n, .port_a_data_oe, .port_a_input_ready,
  .port_b_output_ready, .port_b_data_out, .a_to_b_half_full, .a_to_b_almost_flag);
`default_nettype wire

/* tb/port_host.sv */
// Purpose: host at one port: free port clock and pin level
// Assumes: host drives the pins only while the device does not
// Notes: clock runs free, also between transfers
`timescale 1ns/100ps
`default_nettype none
module port_host #(
  parameter real PHASE = 1.3
) (
  input wire logic oe,
  input wire logic [17:0] dev_data,
  input wire logic [17:0] host_data,
  output logic port_clock,
  output wire logic [17:0] pin
);
  // own phase keeps the two port clocks unrelated
  initial begin
    port_clock = 1'b0;
    #(PHASE);
    forever #80 port_clock = ~port_clock;
  end
  // shared pin: device word while it drives, host word otherwise
  assign pin = oe ? dev_data : host_data;
endmodule // port_host
`default_nettype wire

/* tb/tb_top.sv */
// Purpose: self-checking bench for the buffer pair
// Assumes: controls move at port-clock falls, far from rises
// Notes: full fill and drain a-to-b, one word b-to-a
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic clk = 1'b0, reset = 1'b1, a_to_b_reset_n = 1'b0, b_to_a_reset_n = 1'b0;
  logic port_a_select_n = 1'b1, port_a_dir_select = 1'b1, port_a_write_enable = 1'b0, port_a_read_enable = 1'b0;
  logic port_b_select_n = 1'b1, port_b_dir_select = 1'b1, port_b_write_enable = 1'b0, port_b_read_enable = 1'b0;
  logic [17:0] host_a = 18'h00000, host_b = 18'h00000;
  wire logic port_a_clock, port_b_clock, port_a_data_oe, port_b_data_oe, port_a_input_ready, port_b_input_ready;
  wire logic port_a_output_ready, port_b_output_ready, a_to_b_half_full, b_to_a_half_full, a_to_b_almost_flag;
  wire logic b_to_a_almost_flag;
  wire logic [17:0] port_a_data_in, port_b_data_in, port_a_data_out, port_b_data_out;
  int err_count = 0, n_compared = 0, cnt = 0;
  // 250 MHz system clock
  always #2 clk = ~clk;
  port_host #(.PHASE(1.3)) host_a_i (.oe(port_a_data_oe), .dev_data(port_a_data_out), .host_data(host_a),
    .port_clock(port_a_clock), .pin(port_a_data_in));
  port_host #(.PHASE(57.3)) host_b_i (.oe(port_b_data_oe), .dev_data(port_b_data_out), .host_data(host_b),
    .port_clock(port_b_clock), .pin(port_b_data_in));
  clocked_fifo_pair clocked_fifo_pair_i (.clk, .reset, .port_a_clock, .port_b_clock, .port_a_select_n,
    .port_b_select_n, .port_a_dir_select, .port_b_dir_select, .port_a_write_enable, .port_b_write_enable,
    .port_a_read_enable, .port_b_read_enable, .a_to_b_reset_n, .b_to_a_reset_n, .port_a_data_in,
    .port_b_data_in, .port_a_data_out, .port_b_data_out, .port_a_data_oe, .port_b_data_oe, .port_a_input_ready,
    .port_b_input_ready, .port_a_output_ready, .port_b_output_ready, .a_to_b_half_full, .b_to_a_half_full,
    .a_to_b_almost_flag, .b_to_a_almost_flag);
  task automatic chk(input string what, input logic [17:0] exp, input logic [17:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic [17:0] f(input logic b);
    return {17'h00000, b};
  endfunction
  function automatic logic [17:0] word(input int i);
    return {i[8:0], ~i[8:0]} ^ {i[9], 17'h00000};
  endfunction
  // controls change just after a clk edge following a port-clock fall
  task automatic fall(input bit p);
    if (p) @(negedge port_b_clock);
    else @(negedge port_a_clock);
    @(posedge clk);
    #1;
  endtask
  task automatic rise(input bit p);
    if (p) @(posedge port_b_clock);
    else @(posedge port_a_clock);
  endtask
  // v is select, direction, write enable, read enable, host word
  task automatic drive(input bit p, input logic [21:0] v);
    if (p) {port_b_select_n, port_b_dir_select, port_b_write_enable, port_b_read_enable, host_b} = v;
    else {port_a_select_n, port_a_dir_select, port_a_write_enable, port_a_read_enable, host_a} = v;
  endtask
  // released host lines flip so a stale word never looks valid
  task automatic idle(input bit p);
    fall(p);
    drive(p, {4'b1100, p ? ~host_b : ~host_a});
  endtask
  // word is checked before the edge that consumes it
  task automatic get(input bit p, input logic [17:0] exp);
    logic rdy;
    for (int n = 0; n < 8; n++) begin
      fall(p);
      rdy = p ? port_b_output_ready : port_a_output_ready;
      if (rdy === 1'b1) chk("word", exp, p ? port_b_data_out : port_a_data_out);
      drive(p, {3'b000, rdy === 1'b1, ~exp});
      rise(p);
      if (rdy === 1'b1) return;
    end
    chk("read wait", f(1'b1), f(1'b0));
    print_verdict();
  endtask
  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    #1 reset = 1'b0;
    // clears held over more than four edges of each port clock
    repeat (240) @(posedge clk);
    #1 {a_to_b_reset_n, b_to_a_reset_n} = 2'b11;
    chk("almost a", f(1'b1), f(a_to_b_almost_flag));
    chk("almost b", f(1'b1), f(b_to_a_almost_flag));
    // a write with select high must leave b empty
    drive(0, {4'b1110, 18'h2AAAA});
    repeat (4) idle(1);
    chk("ready b", f(1'b0), f(port_b_output_ready));
    chk("in ready a", f(1'b1), f(port_a_input_ready));
    chk("in ready b", f(1'b1), f(port_b_input_ready));
    chk("half b", f(1'b0), f(b_to_a_half_full));
    // fill a-to-b one word per edge; word 513 is refused
    for (int i = 0; i <= 512; i++) begin
      fall(0);
      if (i inside {12, 13, 255, 256, 499, 500}) begin
        chk("half a", f(i >= 256), f(a_to_b_half_full));
        chk("almost a", f(i <= 12 || i >= 500), f(a_to_b_almost_flag));
      end
      if (i == 512) chk("in ready a", f(1'b0), f(port_a_input_ready));
      drive(0, {4'b0110, word(i)});
    end
    idle(0);
    // drain in order; read enable stays high on the empty buffer
    for (int i = 0; i < 512; i++) get(1, word(i));
    repeat (4) fall(1);
    chk("ready b", f(1'b0), f(port_b_output_ready));
    chk("held word", word(511), port_b_data_out);
    chk("oe b", f(1'b1), f(port_b_data_oe));
    chk("in ready a", f(1'b1), f(port_a_input_ready));
    idle(1);
    // one word b-to-a: count port a edges until it shows
    fall(1);
    drive(1, {4'b0110, 18'h1F0F0});
    rise(1);
    fork
      idle(1);
      while (port_a_output_ready !== 1'b1 && cnt < 8) begin
        rise(0);
        repeat (10) @(posedge clk);
        cnt++;
      end
    join
    chk("ready edges", 18'h00003, 18'(cnt));
    chk("first word", 18'h1F0F0, port_a_data_out);
    get(0, 18'h1F0F0);
    repeat (4) fall(0);
    chk("ready a", f(1'b0), f(port_a_output_ready));
    chk("oe a", f(1'b1), f(port_a_data_oe));
    idle(0);
    fall(0);
    chk("oe a", f(1'b0), f(port_a_data_oe));
    print_verdict();
  end
endmodule // tb_top
`default_nettype wire
